// *** verilog/tape_cue_consts.svh ***
// Clock rate, position reset value and timing counts for the tape position and lathe cue block.
`ifndef TAPE_CUE_CONSTS_SVH
`define TAPE_CUE_CONSTS_SVH
`define CLK_HZ         20000000
`define CUE_TIME_MS    250
`define CUE_CYCLES     ((`CLK_HZ / 1000) * `CUE_TIME_MS)
`define VEL_TIME_MS    100
`define VEL_CYCLES     ((`CLK_HZ / 1000) * `VEL_TIME_MS)
`define POS_RESET      24'h000000
`endif

// *** verilog/tape_cue_pkg.sv ***
// Types shared by the tape position and lathe cue block.
package tape_cue_pkg;
  typedef enum logic [1:0] {
    CUE_IDLE = 2'b00,
    CUE_ON1  = 2'b01,
    CUE_GAP  = 2'b10,
    CUE_ON2  = 2'b11
  } cue_state_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  code;
  } key_event_t;

  typedef struct packed {
    logic band;
    logic lead_out;
    logic expand;
  } cue_out_t;
endpackage : tape_cue_pkg

// *** verilog/tape_position_lathe_cue.sv ***
// Tape position counter, velocity measurement, key dispatch and lathe cue outputs.
`timescale 1ns/1ps
`include "tape_cue_consts.svh"

module tape_position_lathe_cue #(
  parameter int          POS_W      = 24,
  parameter int          VEL_W      = 16,
  parameter int          VARIANT    = 1,
  parameter int unsigned CUE_CYCLES = `CUE_CYCLES,
  parameter int unsigned VEL_CYCLES = `VEL_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    roller_pulse,
  input  wire logic                    tape_forward,
  input  wire logic                    speed_high,
  input  wire logic                    capstan_pulse,
  input  wire logic                    velocity_request,
  input  wire logic                    playback,
  input  wire logic                    key_strobe,
  input  wire logic [4:0]              key_code,
  input  wire logic [POS_W-1:0]        band_pos,
  input  wire logic [POS_W-1:0]        lead_out_pos,
  input  wire logic [POS_W-1:0]        expand_start_pos,
  input  wire logic [POS_W-1:0]        expand_end_pos,
  output logic [POS_W-1:0]             display_pos,
  output logic [VEL_W-1:0]             velocity,
  output logic                         velocity_valid,
  output logic                         measuring,
  output tape_cue_pkg::key_event_t     key_event,
  output tape_cue_pkg::cue_out_t       cue
);
  import tape_cue_pkg::*;

  localparam int TW = 32;

  typedef struct packed {
    logic [1:0]       roll_s;
    logic [1:0]       cap_s;
    logic [1:0]       req_s;
    logic [1:0]       key_s;
    logic [1:0]       fwd_s;
    logic [1:0]       spd_s;
    logic [1:0]       play_s;
    logic [1:0][4:0]  kcode_s;
    logic             roll_d;
    logic             cap_d;
    logic             req_d;
    logic             key_d;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] disp;
    logic             meas;
    logic             cap_half;
    logic [TW-1:0]    vtimer;
    logic [VEL_W-1:0] vcount;
    logic [VEL_W-1:0] vel;
    logic             vel_ok;
    key_event_t       kev;
    cue_state_t       cst;
    logic             lead_sel;
    logic [TW-1:0]    ctimer;
    cue_out_t         out;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic roll_edge;
  logic cap_edge;
  logic req_edge;
  logic key_edge;

  assign roll_edge = st_r.roll_s[1] & ~st_r.roll_d;
  assign cap_edge  = st_r.cap_s[1] & ~st_r.cap_d;
  assign req_edge  = st_r.req_s[1] & ~st_r.req_d;
  assign key_edge  = st_r.key_s[1] & ~st_r.key_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.roll_s = {st_r.roll_s[0], roller_pulse};
    st_nxt.cap_s  = {st_r.cap_s[0], capstan_pulse};
    st_nxt.req_s  = {st_r.req_s[0], velocity_request};
    st_nxt.key_s  = {st_r.key_s[0], key_strobe};
    // Level pins pass two flops as well, so they stay aligned with the edge detectors.
    st_nxt.fwd_s   = {st_r.fwd_s[0], tape_forward};
    st_nxt.spd_s   = {st_r.spd_s[0], speed_high};
    st_nxt.play_s  = {st_r.play_s[0], playback};
    st_nxt.kcode_s = {st_r.kcode_s[0], key_code};
    st_nxt.roll_d = st_r.roll_s[1];
    st_nxt.cap_d  = st_r.cap_s[1];
    st_nxt.req_d  = st_r.req_s[1];
    st_nxt.key_d  = st_r.key_s[1];

    if (roll_edge)
    begin
      st_nxt.pos = st_r.fwd_s[1] ? st_r.pos + 1'b1 : st_r.pos - 1'b1;
    end
    // High speed covers twice the tape per pulse time, so the count is halved for time.
    st_nxt.disp = st_r.spd_s[1] ? (st_r.pos >> 1) : st_r.pos;

    // Velocity measurement window.
    if (!st_r.meas && req_edge)
    begin
      st_nxt.meas     = 1'b1;
      st_nxt.vtimer   = TW'(VEL_CYCLES - 1);
      st_nxt.vcount   = '0;
      st_nxt.cap_half = 1'b0;
      st_nxt.vel_ok   = 1'b0;
    end
    else if (st_r.meas)
    begin
      if (cap_edge)
      begin
        st_nxt.cap_half = ~st_r.cap_half;
        if (st_r.cap_half)
        begin
          st_nxt.vcount = st_r.vcount + 1'b1;
        end
      end
      if (st_r.vtimer == '0)
      begin
        st_nxt.meas   = 1'b0;
        st_nxt.vel    = st_r.vcount;
        st_nxt.vel_ok = 1'b1;
      end
      else
      begin
        st_nxt.vtimer = st_r.vtimer - 1'b1;
      end
    end

    st_nxt.kev.valid = key_edge;
    if (key_edge)
    begin
      st_nxt.kev.code = st_r.kcode_s[1];
    end

    // Expand follows the stored start and end points during playback.
    if (st_r.play_s[1] && st_r.pos == expand_start_pos)
    begin
      st_nxt.out.expand = 1'b1;
    end
    else if (st_r.play_s[1] && st_r.pos == expand_end_pos)
    begin
      st_nxt.out.expand = 1'b0;
    end

    case (st_r.cst)
      CUE_IDLE:
      begin
        if (st_r.play_s[1] && roll_edge == 1'b0 && st_r.pos == band_pos)
        begin
          st_nxt.cst      = CUE_ON1;
          st_nxt.lead_sel = 1'b0;
          st_nxt.ctimer   = TW'(CUE_CYCLES - 1);
          st_nxt.out.band = 1'b1;
        end
        else if (st_r.play_s[1] && roll_edge == 1'b0 && st_r.pos == lead_out_pos)
        begin
          st_nxt.cst      = CUE_ON1;
          st_nxt.lead_sel = 1'b1;
          st_nxt.ctimer   = TW'(CUE_CYCLES - 1);
          if (VARIANT == 1)
          begin
            st_nxt.out.band = 1'b1;
          end
          else
          begin
            st_nxt.out.lead_out = 1'b1;
          end
        end
      end
      CUE_ON1, CUE_GAP, CUE_ON2:
      begin
        if (st_r.ctimer != '0)
        begin
          st_nxt.ctimer = st_r.ctimer - 1'b1;
        end
        else if (st_r.cst == CUE_ON1 && st_r.lead_sel && VARIANT == 1)
        begin
          st_nxt.cst      = CUE_GAP;
          st_nxt.ctimer   = TW'(CUE_CYCLES - 1);
          st_nxt.out.band = 1'b0;
        end
        else if (st_r.cst == CUE_GAP)
        begin
          st_nxt.cst      = CUE_ON2;
          st_nxt.ctimer   = TW'(CUE_CYCLES - 1);
          st_nxt.out.band = 1'b1;
        end
        else if (st_r.pos != band_pos && st_r.pos != lead_out_pos)
        begin
          // Waiting until the position leaves the cue point keeps one cue per pass.
          st_nxt.cst          = CUE_IDLE;
          st_nxt.out.band     = 1'b0;
          st_nxt.out.lead_out = 1'b0;
        end
        else
        begin
          st_nxt.out.band     = 1'b0;
          st_nxt.out.lead_out = 1'b0;
        end
      end
      default:
      begin
        st_nxt.cst = CUE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r        <= '0;
      st_r.pos    <= `POS_RESET;
      st_r.cst    <= CUE_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign display_pos    = st_r.disp;
  assign velocity       = st_r.vel;
  assign velocity_valid = st_r.vel_ok;
  assign measuring      = st_r.meas;
  assign key_event      = st_r.kev;
  assign cue            = st_r.out;

  ////////////////////////////////////////////////////////////////////////////
  a_roll_step: assert property (@(posedge core_clk) disable iff (rst)
    roll_edge && st_r.fwd_s[1] |=> st_r.pos == $past(st_r.pos) + 1'b1)
    else $error("position did not step up");
  a_disp_scale: assert property (@(posedge core_clk) disable iff (rst)
    st_r.spd_s[1] |=> st_r.disp == ($past(st_r.pos) >> 1))
    else $error("display not scaled");
  a_idle_count: assert property (@(posedge core_clk) disable iff (rst)
    !st_r.meas && !req_edge |=> $stable(st_r.vcount))
    else $error("count moved outside measurement");
  a_half_rate: assert property (@(posedge core_clk) disable iff (rst)
    st_r.meas && cap_edge && !st_r.cap_half && st_r.vtimer != '0 |=> $stable(st_r.vcount))
    else $error("count advanced on odd pulse");
  a_vel_end: assert property (@(posedge core_clk) disable iff (rst)
    st_r.meas && st_r.vtimer == '0 |=> !st_r.meas && st_r.vel_ok)
    else $error("measurement did not end");
  a_key_event: assert property (@(posedge core_clk) disable iff (rst)
    key_edge |=> key_event.valid && key_event.code == $past(st_r.kcode_s[1]))
    else $error("key event missing");
  a_cue_play: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cue.band) && $past(st_r.cst) == CUE_IDLE |-> $past(st_r.play_s[1]))
    else $error("cue outside playback");
  a_band_len: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cue.band) |=> cue.band [*3])
    else $error("band pulse too short");
  a_expand_on: assert property (@(posedge core_clk) disable iff (rst)
    st_r.play_s[1] && st_r.pos == expand_start_pos |=> cue.expand)
    else $error("expand not on at start");
  c_band: cover property (@(posedge core_clk) $rose(cue.band));
  c_lead: cover property (@(posedge core_clk) st_r.cst == CUE_ON2);
  c_vel:  cover property (@(posedge core_clk) $rose(st_r.vel_ok));
endmodule : tape_position_lathe_cue

// *** verification/lathe_model.sv ***
// Record lathe model that senses the band and lead_out cue outputs and measures each pulse.
`timescale 1ns/1ps
module lathe_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire tape_cue_pkg::cue_out_t cue,
  output logic [7:0]                  band_n,
  output logic [7:0]                  band_len,
  output logic [7:0]                  lead_n,
  output logic [7:0]                  lead_len
);
  import tape_cue_pkg::*;
  cue_out_t   prev;
  logic [7:0] bc;
  logic [7:0] lc;
  // A conducting driver reads high; the lathe counts rises and times the last pulse.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      {prev, bc, lc, band_n, band_len, lead_n, lead_len} <= '0;
    end
    else
    begin
      prev <= cue;
      bc   <= cue.band ? bc + 8'h01 : 8'h00;
      lc   <= cue.lead_out ? lc + 8'h01 : 8'h00;
      if (cue.band && !prev.band) band_n <= band_n + 8'h01;
      if (!cue.band && prev.band) band_len <= bc;
      if (cue.lead_out && !prev.lead_out) lead_n <= lead_n + 8'h01;
      if (!cue.lead_out && prev.lead_out) lead_len <= lc;
    end
  end
endmodule : lathe_model

// *** verification/tb_top.sv ***
// Self-checking bench for the tape position and lathe cue block.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
`define WAITV(s, v) for (k = 0; k < 200 && (s) !== (v); k++) tick(1); \
  if ((s) !== (v)) begin n_fail++; end_sim(); end
module tb_top;
  import tape_cue_pkg::*;
  localparam int CC = 4;
  logic        core_clk = 0, rst = 1, roller_pulse = 0, tape_forward = 1, speed_high = 0;
  logic        capstan_pulse = 0, velocity_request = 0, playback = 0, key_strobe = 0;
  logic [4:0]  key_code = 5'h00;
  logic [23:0] band_pos, lead_out_pos, expand_start_pos, expand_end_pos, display_pos, exp_pos;
  logic [15:0] velocity;
  logic        velocity_valid, measuring;
  key_event_t  key_event;
  cue_out_t    cue1, cue2;
  logic [7:0]  bn1, bl1, ln1, ll1, bn2, bl2, ln2, ll2;
  int          n_fail = 0, samples_checked = 0, i, k;

  tape_position_lathe_cue #(.VARIANT(1), .CUE_CYCLES(CC), .VEL_CYCLES(50)) DUT (.*, .cue(cue1));
  tape_position_lathe_cue #(.VARIANT(2), .CUE_CYCLES(CC), .VEL_CYCLES(50)) DUT2 (.*, .cue(cue2),
    .display_pos(), .velocity(), .velocity_valid(), .measuring(), .key_event());
  lathe_model L1 (.core_clk, .rst, .cue(cue1), .band_n(bn1), .band_len(bl1), .lead_n(ln1), .lead_len(ll1));
  lathe_model L2 (.core_clk, .rst, .cue(cue2), .band_n(bn2), .band_len(bl2), .lead_n(ln2), .lead_len(ll2));

  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  function automatic logic [23:0] disp_exp();
    return speed_high ? (exp_pos >> 1) : exp_pos;
  endfunction : disp_exp

  task automatic step(input logic fwd);
    tape_forward = fwd;
    roller_pulse = 1;
    tick(2);
    roller_pulse = 0;
    tick(2);
    exp_pos = fwd ? exp_pos + 24'h000001 : exp_pos - 24'h000001;
  endtask : step

  task automatic capstan(input int n);
    repeat (n)
    begin
      capstan_pulse = 1;
      tick(2);
      capstan_pulse = 0;
      tick(2);
    end
  endtask : capstan

  task automatic vel(input int n);
    velocity_request = 1;
    tick(2);
    velocity_request = 0;
    tick(3);
    `CHK(measuring, 1'b1)
    `CHK(velocity_valid, 1'b0)
    capstan(n);
    `WAITV(measuring, 1'b0)
    `CHK(velocity, 16'(n / 2))
    `CHK(velocity_valid, 1'b1)
  endtask : vel

  ////////////////////////////////////////////////////////////////
  initial
  begin
    band_pos = 24'h400000;
    lead_out_pos = 24'h400010;
    expand_start_pos = 24'h400020;
    expand_end_pos = 24'h400030;
    exp_pos = 24'h000000;
    void'($urandom(47661));
    tick(10);
    rst = 0;
    tick(1);
    `CHK(cue1, 3'h0)
    `CHK(cue2, 3'h0)
    `CHK(display_pos, 24'h000000)
    // Stepping down from zero first exercises the wrap of the count.
    step(0);
    for (i = 0; i < 40; i++)
    begin
      if (i > 0) step(1'($urandom_range(1, 0)));
      speed_high = 1'($urandom_range(1, 0));
      tick(4);
      `CHK(display_pos, disp_exp())
    end
    $display("test position done");
    for (i = 0; i < 32; i++)
    begin
      key_code = 5'(i);
      key_strobe = 1;
      tick(2);
      key_strobe = 0;
      `WAITV(key_event.valid, 1'b1)
      `CHK(key_event.code, 5'(i))
      tick(2);
    end
    $display("test keys done");
    capstan(3);
    `CHK(measuring, 1'b0)
    vel(0);
    vel(7);
    vel(int'($urandom_range(9, 1)));
    $display("test velocity done");
    band_pos = exp_pos + 24'h000001;
    step(1);
    step(1);
    tick(CC + 6);
    `CHK(bn1, 8'h00)
    playback = 1;
    band_pos = exp_pos + 24'h000001;
    step(1);
    tick(CC + 6);
    `CHK(bn1, 8'h01)
    `CHK(bl1, 8'(CC))
    `CHK(bn2, 8'h01)
    `CHK(bl2, 8'(CC))
    // The cue engine rearms only once the position has left every cue point.
    lead_out_pos = exp_pos + 24'h000002;
    step(1);
    step(1);
    tick(3 * CC + 6);
    `CHK(bn1, 8'h03)
    `CHK(bl1, 8'(CC))
    `CHK(ln1, 8'h00)
    `CHK(ln2, 8'h01)
    `CHK(ll2, 8'(CC))
    `CHK(bn2, 8'h01)
    expand_start_pos = exp_pos + 24'h000001;
    expand_end_pos = exp_pos + 24'h000003;
    step(1);
    tick(2);
    `CHK(cue1.expand, 1'b1)
    `CHK(cue2.expand, 1'b1)
    step(1);
    tick(2);
    `CHK(cue2.expand, 1'b1)
    step(1);
    tick(2);
    `CHK(cue1.expand, 1'b0)
    `CHK(cue2.expand, 1'b0)
    $display("test cues done");
    end_sim();
  end
endmodule : tb_top
